// ---- rtl/toc_counter.sv ----
// One channel counter with clear, up/down and wrap detection
module toc_counter
    import toc_pkg::*;
#(
    parameter int W = CNT_W
)
(
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic         tick,
    input  wire logic         updown,
    input  wire logic         clr,
    input  wire logic         wr,
    input  wire logic [W-1:0] wdata,
    output logic [W-1:0]      cnt_ff,
    output logic              ovf_ff,
    output logic              udf_ff
);
    if (W < 2) begin : g_width_chk
        $error("Counter width too small");
    end

    logic         down_ff;
    logic         nxt_down;
    logic [W-1:0] nxt_cnt;
    logic         wrap_up;
    logic         wrap_dn;

    assign wrap_up = tick && !down_ff && (cnt_ff == {W{1'b1}});
    assign wrap_dn = tick && down_ff && (cnt_ff == '0);
    // Direction turns at the ends only in up/down mode
    // Bottom turn counts as the underflow, so a falling count never wraps
    assign nxt_down = !updown ? 1'b0 :
                      (tick && !down_ff && cnt_ff == {W{1'b1}} - 1'b1) ? 1'b1 :
                      wrap_dn ? 1'b0 : down_ff;
    assign nxt_cnt = wr ? wdata :
                     clr ? '0 :
                     !tick ? cnt_ff :
                     (down_ff && !wrap_dn) ? cnt_ff - 1'b1 : cnt_ff + 1'b1;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff  <= CNT_RST;
            down_ff <= 1'b0;
            ovf_ff  <= 1'b0;
            udf_ff  <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            down_ff <= nxt_down;
            ovf_ff  <= wrap_up && !wr && !clr;
            udf_ff  <= wrap_dn && !wr && !clr;
        end
    end
endmodule

// ---- rtl/toc_pkg.sv ----
// Package for the timer output control and counter block
package toc_pkg;
    localparam int          NUM_CH          = 2;
    localparam int          NUM_PINS        = 8;
    localparam int          CNT_W           = 16;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 16;
    localparam int          PSC_W           = 3;
    localparam int          CCLR_W          = 2;
    // Register offsets
    localparam logic [3:0]  OFF_OUT_EN      = 4'h0;
    localparam logic [3:0]  OFF_INIT_LVL    = 4'h1;
    localparam logic [3:0]  OFF_CNT0        = 4'h2;
    localparam logic [3:0]  OFF_CNT1        = 4'h3;
    localparam logic [3:0]  OFF_FUNC_CTRL   = 4'h4;
    localparam logic [3:0]  OFF_TIMER_CTRL  = 4'h5;
    localparam logic [3:0]  OFF_STATUS      = 4'h6;
    localparam logic [3:0]  OFF_IRQ_MASK    = 4'h7;
    // Reset values
    localparam logic [7:0]  OUT_EN_RST      = 8'hff;
    localparam logic [7:0]  INIT_LVL_RST    = 8'h00;
    localparam logic [15:0] CNT_RST         = 16'h0000;
    // Function control fields
    localparam int          FC_CMD_LSB      = 0;
    localparam int          FC_NORMAL_PHASE_LEVEL_SEL_BIT     = 2;
    localparam int          FC_COUNTER_PHASE_LEVEL_SEL_BIT     = 3;
    // Timer control fields, per channel byte: [2:0] prescaler, [4:3] clear select
    localparam int          TC_PSC_LSB      = 0;
    localparam int          TC_CCLR_LSB     = 3;
    localparam int          TC_CH_STRIDE    = 8;
    // Status bits
    localparam int          ST_OVF0_BIT     = 0;
    localparam int          ST_OVF1_BIT     = 1;
    localparam int          ST_UDF_BIT      = 2;
    localparam int          ST_W            = 3;
    // Prescaler dividers
    localparam logic [2:0]  PSC_DIV1        = 3'h0;
    localparam logic [2:0]  PSC_DIV2        = 3'h1;
    localparam logic [2:0]  PSC_DIV4        = 3'h2;
    localparam logic [2:0]  PSC_DIV8        = 3'h3;
    localparam int          PSC_EXT_BIT     = 2;
    // Clear sources
    localparam logic [1:0]  CCLR_NONE       = 2'h0;
    localparam logic [1:0]  CCLR_GR_FIRST   = 2'h1;
    localparam logic [1:0]  CCLR_GR_SECOND  = 2'h2;

    typedef enum logic [1:0] {
        TOC_MODE_NORMAL,
        TOC_MODE_RSYNC_PWM,
        TOC_MODE_CPWM_TROUGH,
        TOC_MODE_CPWM_CREST
    } toc_mode_t;
endpackage

// ---- rtl/toc_prescaler.sv ----
// Count-enable generator: internal divider or external clock edge
module toc_prescaler
    import toc_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic [PSC_W-1:0] sel,
    input  wire logic             ext_clk,
    output logic                  tick_ff
);
    logic [2:0] div_ff;
    logic       ext_ff;
    logic       div_hit;

    assign div_hit = (sel == PSC_DIV1) ? 1'b1 :
                     (sel == PSC_DIV2) ? (div_ff[0] == 1'b1) :
                     (sel == PSC_DIV4) ? (div_ff[1:0] == 2'h3) :
                     (div_ff == 3'h7);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_ff  <= 3'h0;
            ext_ff  <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= div_ff + 3'h1;
            ext_ff  <= ext_clk;
            // External source counts on rising edges only
            tick_ff <= sel[PSC_EXT_BIT] ? (ext_clk & ~ext_ff) : div_hit;
        end
    end
endmodule

// ---- rtl/toc_top.sv ----
// Timer output enables, initial levels, channel counters and status
// Function
// - Enable bit 0 lets timer drive pin; 1 hands pin to general I/O.
// - Enable bits 7..4 channel 1 D..A, 3..0 channel 0; reset to ones.
// - Low on selected wakeup input sets all enable bits to one.
// - Initial-level bits, same order, reset zero, drive pin until first match.
// - In both PWM combination modes initial levels come from level-select bits.
// - Writing an initial-level bit sets the pin at once: to that bit in normal mode, to the level-select initial level in PWM modes.
// - Two 16-bit counters, each clocked by its prescaler selection.
// - Complementary PWM counts up and down; other modes only up.
// - Selected general register match or capture clears the counter.
// - Counter overflow sets that channel's overflow flag.
// - Channel 1 underflow sets the underflow flag.
// - Level-select 0 gives high initial, 1 low; counter then normal phase.
// - Mode 00 normal, 01 reset-sync PWM, 10/11 complementary PWM.
//
// The register offsets and strobed register access were chosen for this implementation.
module toc_top
    import toc_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [DATA_W-1:0]         reg_rdata,
    input  wire logic                 wakeup_input_sel,
    input  wire logic                 wakeup_shutdown_pin,
    input  wire logic                 ext_count_clk,
    input  wire logic [NUM_PINS-1:0]  compare_match,
    input  wire logic [NUM_PINS-1:0]  input_capture,
    input  wire logic [NUM_PINS-1:0]  mode_pin_level,
    output logic [NUM_PINS-1:0]       timer_pin_out,
    output logic [NUM_PINS-1:0]       timer_pin_oe,
    output logic [1:0]                combination_mode,
    output logic                      irq
);
    logic [7:0]             out_en_ff;
    logic [7:0]             init_lvl_ff;
    logic [7:0]             func_ctrl_ff;
    logic [15:0]            timer_ctrl_ff;
    logic [ST_W-1:0]        status_ff;
    logic [ST_W-1:0]        mask_ff;
    logic [NUM_PINS-1:0]    started_ff;
    logic [DATA_W-1:0]      rdata_ff;
    logic [NUM_PINS-1:0]    pin_out_ff;
    logic [NUM_PINS-1:0]    pin_oe_ff;
    logic [1:0]             mode_ff;
    logic                   irq_ff;

    logic [CNT_W-1:0]       cnt     [NUM_CH];
    logic [NUM_CH-1:0]      ovf;
    logic [NUM_CH-1:0]      underflow_flag;
    logic [NUM_CH-1:0]      tick;
    logic [NUM_CH-1:0]      clr;
    logic [NUM_CH-1:0]      cnt_wr;

    logic                   wr_out_en;
    logic                   wr_init_lvl;
    logic                   wr_func;
    logic                   wr_tctrl;
    logic                   wr_mask;
    logic                   rd_status;
    logic                   shutdown;
    logic                   pwm_combo;
    logic                   cpwm;
    logic [ST_W-1:0]        events;
    logic [NUM_PINS-1:0]    init_sel;
    logic [NUM_PINS-1:0]    nxt_pin_out;
    logic [NUM_PINS-1:0]    nxt_started;
    logic [DATA_W-1:0]      nxt_rdata;
    toc_mode_t              mode;

    // Write and read decode
    assign wr_out_en   = reg_wr && (reg_addr == OFF_OUT_EN);
    assign wr_init_lvl = reg_wr && (reg_addr == OFF_INIT_LVL);
    assign cnt_wr[0]   = reg_wr && (reg_addr == OFF_CNT0);
    assign cnt_wr[1]   = reg_wr && (reg_addr == OFF_CNT1);
    assign wr_func     = reg_wr && (reg_addr == OFF_FUNC_CTRL);
    assign wr_tctrl    = reg_wr && (reg_addr == OFF_TIMER_CTRL);
    assign wr_mask     = reg_wr && (reg_addr == OFF_IRQ_MASK);
    assign rd_status   = reg_rd && (reg_addr == OFF_STATUS);

    assign nxt_rdata =
        (reg_addr == OFF_OUT_EN)     ? {8'h00, out_en_ff} :
        (reg_addr == OFF_INIT_LVL)   ? {8'h00, init_lvl_ff} :
        (reg_addr == OFF_CNT0)       ? cnt[0] :
        (reg_addr == OFF_CNT1)       ? cnt[1] :
        (reg_addr == OFF_FUNC_CTRL)  ? {8'h00, func_ctrl_ff} :
        (reg_addr == OFF_TIMER_CTRL) ? timer_ctrl_ff :
        (reg_addr == OFF_STATUS)     ? {13'h0000, status_ff} :
        (reg_addr == OFF_IRQ_MASK)   ? {13'h0000, mask_ff} :
        16'h0000;

    // Mode decode
    assign mode      = toc_mode_t'(func_ctrl_ff[FC_CMD_LSB +: 2]);
    assign pwm_combo = (mode != TOC_MODE_NORMAL);
    assign cpwm      = (mode == TOC_MODE_CPWM_TROUGH) || (mode == TOC_MODE_CPWM_CREST);

    // Shutdown input is taken as synchronous
    assign shutdown = wakeup_input_sel && !wakeup_shutdown_pin;

    // Pin order per channel: bit 3 D is counter phase, bits 2..0 normal phase
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            localparam bit CPH = ((g % 4) == 3);
            // Level-select 0 means start high
            assign init_sel[g] = pwm_combo ?
                ~func_ctrl_ff[CPH ? FC_COUNTER_PHASE_LEVEL_SEL_BIT : FC_NORMAL_PHASE_LEVEL_SEL_BIT] :
                init_lvl_ff[g];
            assign nxt_started[g] = (started_ff[g] || compare_match[g]) && !wr_init_lvl;
            // A write to the level register re-arms the initial level at once
            assign nxt_pin_out[g] = wr_init_lvl ? (pwm_combo ? init_sel[g] : reg_wdata[g]) :
                                    nxt_started[g] ? mode_pin_level[g] : init_sel[g];
        end
    endgenerate

    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic [PSC_W-1:0]  psc;
            logic [CCLR_W-1:0] cclr;
            logic              src;
            assign psc  = timer_ctrl_ff[g*TC_CH_STRIDE + TC_PSC_LSB +: PSC_W];
            assign cclr = timer_ctrl_ff[g*TC_CH_STRIDE + TC_CCLR_LSB +: CCLR_W];
            assign src  = (cclr == CCLR_GR_FIRST)  ? (compare_match[g*4] | input_capture[g*4]) :
                          (cclr == CCLR_GR_SECOND) ? (compare_match[g*4+1] | input_capture[g*4+1]) :
                          1'b0;
            assign clr[g] = (cclr != CCLR_NONE) && src;

            toc_prescaler u_psc (
                .ref_clk (ref_clk),
                .rstn    (rstn),
                .sel     (psc),
                .ext_clk (ext_count_clk),
                .tick_ff (tick[g])
            );

            toc_counter #(.W(CNT_W)) u_cnt (
                .ref_clk (ref_clk),
                .rstn    (rstn),
                .tick    (tick[g]),
                .updown  (cpwm),
                .clr     (clr[g]),
                .wr      (cnt_wr[g]),
                .wdata   (reg_wdata),
                .cnt_ff  (cnt[g]),
                .ovf_ff  (ovf[g]),
                .udf_ff  (underflow_flag[g])
            );
        end
    endgenerate

    assign events[ST_OVF0_BIT] = ovf[0];
    assign events[ST_OVF1_BIT] = ovf[1];
    assign events[ST_UDF_BIT]  = underflow_flag[1];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            out_en_ff <= OUT_EN_RST;
        end else if (shutdown) begin
            out_en_ff <= OUT_EN_RST;
        end else if (wr_out_en) begin
            out_en_ff <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            init_lvl_ff   <= INIT_LVL_RST;
            func_ctrl_ff  <= 8'h00;
            timer_ctrl_ff <= 16'h0000;
            mask_ff       <= '0;
        end else begin
            if (wr_init_lvl) init_lvl_ff <= reg_wdata[7:0];
            if (wr_func) func_ctrl_ff <= reg_wdata[7:0];
            if (wr_tctrl) timer_ctrl_ff <= reg_wdata;
            if (wr_mask) mask_ff <= reg_wdata[ST_W-1:0];
        end
    end

    // Set beats the read-clear in the same cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            status_ff <= '0;
        end else begin
            status_ff <= (rd_status ? '0 : status_ff) | events;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            started_ff <= '0;
            pin_out_ff <= INIT_LVL_RST;
            pin_oe_ff  <= '0;
            rdata_ff   <= '0;
            mode_ff    <= 2'h0;
            irq_ff     <= 1'b0;
        end else begin
            started_ff <= nxt_started;
            pin_out_ff <= nxt_pin_out;
            // Shutdown drops the drivers in the same edge as the enable bits
            pin_oe_ff  <= shutdown ? '0 :
                          wr_out_en ? ~reg_wdata[7:0] : ~out_en_ff;
            rdata_ff   <= reg_rd ? nxt_rdata : 16'h0000;
            mode_ff    <= func_ctrl_ff[FC_CMD_LSB +: 2];
            irq_ff     <= |(((rd_status ? '0 : status_ff) | events) & mask_ff);
        end
    end

    assign reg_rdata        = rdata_ff;
    assign timer_pin_out    = pin_out_ff;
    assign timer_pin_oe     = pin_oe_ff;
    assign combination_mode = mode_ff;
    assign irq              = irq_ff;
endmodule

// ---- sim/timer_output_control_counter_tb_top.sv ----
// Self-checking bench for the timer output block
module timer_output_control_counter_tb_top
    import toc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic              ref_clk, rstn, reg_wr, reg_rd, wk_sel, shut_req, ext_run, irq, wk_pin, ext_clk;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rv, rv2;
    logic [7:0]        cmp, cap, lvl, pin_out, pin_oe, pin_lvl, d, p;
    logic [1:0]        mode;
    logic [31:0]       seed = 32'h000115b7;
    int                fails = 0, checks_done = 0, cyc = 0, i;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // D pins take the counter-phase select, A to C the normal-phase one
    function automatic logic [7:0] pwm_init(logic [1:0] ols);
        return {~ols[1], {3{~ols[0]}}, ~ols[1], {3{~ols[0]}}};
    endfunction
    function automatic logic [15:0] exp_delta(logic [2:0] s);
        return s[2] ? 16'h0004 : 16'h0018 >> s[1:0];
    endfunction
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(input logic [7:0] c, input logic [7:0] k);
        @(posedge ref_clk);
        cmp <= c;
        cap <= k;
        @(posedge ref_clk);
        cmp <= 8'h00;
        cap <= 8'h00;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    toc_top i_dut (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .wakeup_input_sel(wk_sel), .wakeup_shutdown_pin(wk_pin), .ext_count_clk(ext_clk),
        .compare_match(cmp), .input_capture(cap), .mode_pin_level(lvl),
        .timer_pin_out(pin_out), .timer_pin_oe(pin_oe), .combination_mode(mode), .irq);
    toc_pin_model i_pins (.ref_clk, .rstn, .timer_pin_out(pin_out), .timer_pin_oe(pin_oe), .shut_req,
        .ext_run, .wakeup_shutdown_pin(wk_pin), .ext_count_clk(ext_clk), .pin_level(pin_lvl));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Whole run needs about 470 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        rstn = 1'b0;
        {reg_wr, reg_rd, wk_sel, shut_req} = 4'h0;
        ext_run = 1'b1;
        {reg_addr, reg_wdata, cmp, cap, lvl} = '0;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(OFF_OUT_EN, rv);
        chk(rv, {8'h00, OUT_EN_RST});
        rd(OFF_INIT_LVL, rv);
        chk(rv, {8'h00, INIT_LVL_RST});
        chk({pin_oe, pin_out}, 16'h0000);
        rd({1'b1, 3'(xs())}, rv);
        chk(rv, 16'h0000);
        for (i = 0; i < 6; i++) begin
            d = 8'(xs());
            wr(OFF_OUT_EN, 16'(d));
            rd(OFF_OUT_EN, rv);
            chk(rv, 16'(d));
            chk(16'(pin_oe), {8'h00, ~d});
            chk(16'(pin_lvl), 16'((pin_out & ~d) | d));
        end
        wr(OFF_OUT_EN, 16'h0000);
        @(posedge ref_clk);
        wk_sel <= 1'b1;
        shut_req <= 1'b1;
        cyc_n(3);
        wr(OFF_OUT_EN, 16'h0000);
        rd(OFF_OUT_EN, rv);
        chk(rv, 16'h00ff);
        chk(16'(pin_oe), 16'h0000);
        @(posedge ref_clk);
        wk_sel <= 1'b0;
        wr(OFF_OUT_EN, 16'h0000);
        cyc_n(3);
        rd(OFF_OUT_EN, rv);
        chk(rv, 16'h0000);
        @(posedge ref_clk);
        shut_req <= 1'b0;
        for (i = 0; i < 4; i++) begin
            d = 8'(xs());
            p = 8'h01 << 3'(xs());
            wr(OFF_INIT_LVL, 16'(d));
            cyc_n(1);
            chk(16'(pin_out), 16'(d));
            lvl <= ~d;
            pulse(p, 8'h00);
            cyc_n(2);
            chk(16'(pin_out), 16'(d ^ p));
        end
        for (i = 0; i < 4; i++) begin
            wr(OFF_FUNC_CTRL, {12'h000, 2'(i), 2'(i % 3 + 1)});
            wr(OFF_INIT_LVL, 16'h005a);
            cyc_n(2);
            chk(16'(mode), 16'(i % 3 + 1));
            chk(16'(pin_out), 16'(pwm_init(2'(i))));
        end
        wr(OFF_FUNC_CTRL, 16'h0000);
        for (i = 0; i < 5; i++) begin
            wr(OFF_TIMER_CTRL, 16'(i));
            cyc_n(10);
            rd(OFF_CNT0, rv);
            cyc_n(22);
            rd(OFF_CNT0, rv2);
            chk(rv2 - rv, exp_delta(3'(i)));
        end
        wr(OFF_TIMER_CTRL, 16'h0000);
        wr(OFF_FUNC_CTRL, 16'h0002);
        wr(OFF_CNT1, 16'hfff0);
        cyc_n(20);
        rd(OFF_CNT1, rv);
        cyc_n(22);
        rd(OFF_CNT1, rv2);
        chk(rv - rv2, 16'h0018);
        wr(OFF_CNT1, 16'h0008);
        cyc_n(14);
        rd(OFF_STATUS, rv);
        chk(rv, 16'h0004);
        wr(OFF_FUNC_CTRL, 16'h0000);
        wr(OFF_CNT1, 16'h0000);
        wr(OFF_IRQ_MASK, 16'h0000);
        rd(OFF_STATUS, rv);
        wr(OFF_CNT0, 16'hfff0);
        cyc_n(30);
        chk(16'(irq), 16'h0000);
        rd(OFF_STATUS, rv);
        chk(rv, 16'h0001);
        rd(OFF_STATUS, rv);
        chk(rv, 16'h0000);
        wr(OFF_CNT0, 16'hfff0);
        wr(OFF_IRQ_MASK, 16'h0001);
        cyc_n(30);
        chk(16'(irq), 16'h0001);
        rd(OFF_STATUS, rv);
        cyc_n(2);
        chk(16'(irq), 16'h0000);
        wr(OFF_TIMER_CTRL, 16'h1008);
        pulse(8'h01, 8'h20);
        rd(OFF_CNT0, rv);
        chk(rv & 16'hfffc, 16'h0000);
        rd(OFF_CNT1, rv);
        chk(rv & 16'hfff8, 16'h0000);
        wr(OFF_CNT0, 16'h8000);
        pulse(8'h02, 8'h00);
        rd(OFF_CNT0, rv);
        chk(rv & 16'hff00, 16'h8000);
        report_and_stop();
    end
endmodule

// ---- sim/toc_assertions.sv ----
// Port-level checker for the timer output block
module toc_checker
    import toc_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rstn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              wakeup_input_sel,
    input wire logic              wakeup_shutdown_pin,
    input wire logic              ext_count_clk,
    input wire logic [7:0]        compare_match,
    input wire logic [7:0]        input_capture,
    input wire logic [7:0]        mode_pin_level,
    input wire logic [7:0]        timer_pin_out,
    input wire logic [7:0]        timer_pin_oe,
    input wire logic [1:0]        combination_mode,
    input wire logic              irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire logic shut  = wakeup_input_sel && !wakeup_shutdown_pin;
    wire logic oe_wr = reg_wr && reg_addr == OFF_OUT_EN;
    wire logic fc_wr = reg_wr && reg_addr == OFF_FUNC_CTRL;
    wire logic mk_wr = reg_wr && reg_addr == OFF_IRQ_MASK;
    property p_oe;
        logic [7:0] d;
        (oe_wr && !shut && !$past(shut), d = reg_wdata[7:0]) ##1 (!oe_wr && !shut) |=> timer_pin_oe == ~d;
    endproperty
    property p_init;
        logic [7:0] d;
        (reg_wr && reg_addr == OFF_INIT_LVL && combination_mode == 2'h0 && compare_match == 8'h00,
            d = reg_wdata[7:0]) ##1 (compare_match == 8'h00 && combination_mode == 2'h0) |=> timer_pin_out == d;
    endproperty
    property p_mode;
        logic [1:0] m;
        (fc_wr, m = reg_wdata[1:0]) ##1 !fc_wr |=> combination_mode == m;
    endproperty
    oe_follow_a: assert property (p_oe) else $error("pin enable mismatch");
    shut_force_a: assert property (shut ##1 shut |=> timer_pin_oe == 8'h00) else $error("shutdown ignored");
    init_level_a: assert property (p_init) else $error("initial level mismatch");
    mode_copy_a: assert property (p_mode) else $error("mode mismatch");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("read data not idle");
    unmapped_rd_a: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 16'h0000) else $error("unmapped read");
    byte_reg_a: assert property (reg_rd && reg_addr < OFF_CNT0 |=> reg_rdata[15:8] == 8'h00) else $error("upper set");
    irq_masked_a: assert property (mk_wr && reg_wdata[2:0] == 3'h0 ##1 !mk_wr |=> !irq) else $error("masked irq");
    cover property (shut ##1 shut);
    cover property ($rose(irq));
    cover property (combination_mode == 2'h2);
endmodule
bind toc_top toc_checker i_chk (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .wakeup_input_sel, .wakeup_shutdown_pin, .ext_count_clk, .compare_match, .input_capture,
    .mode_pin_level, .timer_pin_out, .timer_pin_oe, .combination_mode, .irq);

// ---- sim/toc_pin_model.sv ----
// Pin-side model: pulled-up timer pins, wakeup line and external count clock
module toc_pin_model
    import toc_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire logic [NUM_PINS-1:0] timer_pin_out,
    input  wire logic [NUM_PINS-1:0] timer_pin_oe,
    input  wire logic                shut_req,
    input  wire logic                ext_run,
    output logic                     wakeup_shutdown_pin,
    output logic                     ext_count_clk,
    output logic [NUM_PINS-1:0]      pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div_ff;
    logic       ext_ff;
    // Released pins float up, so a stale timer value never shows
    assign pin_level = (timer_pin_out & timer_pin_oe) | ~timer_pin_oe;
    assign wakeup_shutdown_pin = ~shut_req;
    assign ext_count_clk = ext_ff;
    // Six-cycle period keeps the edge count in a window exact
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_ff <= 3'h0;
            ext_ff <= 1'b0;
        end else begin
            div_ff <= (div_ff == 3'h5) ? 3'h0 : div_ff + 3'h1;
            ext_ff <= ext_run && (div_ff < 3'h3);
        end
    end
endmodule
